//--- src/stg_pkg.sv
// Constants for the two-wire temperature monitor target: pointers, resets, masks, timing.
// Assumes a 50 MHz core clock; imported by stg_target and its bench only.
package stg_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h4C;
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam int TIMEOUT_MS = 25;
	localparam int CORE_CLK_HZ = 50000000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CORE_CLK_HZ / 1000);
	// Arbitrary identification value
	localparam logic [7:0] MAKER_ID_DEFAULT = 8'hA5;
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] P_LOCAL_HI = 8'h00;
	localparam logic [7:0] P_REMOTE_HI = 8'h01;
	localparam logic [7:0] P_STATUS = 8'h02;
	localparam logic [7:0] P_CFG_RD = 8'h03;
	localparam logic [7:0] P_RATE_RD = 8'h04;
	localparam logic [7:0] P_LHL_RD = 8'h05;
	localparam logic [7:0] P_LLL_RD = 8'h06;
	localparam logic [7:0] P_RHL_RD = 8'h07;
	localparam logic [7:0] P_RLL_RD = 8'h08;
	localparam logic [7:0] P_CFG_WR = 8'h09;
	localparam logic [7:0] P_RATE_WR = 8'h0A;
	localparam logic [7:0] P_LHL_WR = 8'h0B;
	localparam logic [7:0] P_LLL_WR = 8'h0C;
	localparam logic [7:0] P_RHL_WR = 8'h0D;
	localparam logic [7:0] P_RLL_WR = 8'h0E;
	localparam logic [7:0] P_ONESHOT = 8'h0F;
	localparam logic [7:0] P_REMOTE_LO = 8'h10;
	localparam logic [7:0] P_OFS_HI = 8'h11;
	localparam logic [7:0] P_OFS_LO = 8'h12;
	localparam logic [7:0] P_RHL_LO = 8'h13;
	localparam logic [7:0] P_RLL_LO = 8'h14;
	localparam logic [7:0] P_LOCAL_LO = 8'h15;
	localparam logic [7:0] P_RCRIT = 8'h19;
	localparam logic [7:0] P_LCRIT = 8'h20;
	localparam logic [7:0] P_HYST = 8'h21;
	localparam logic [7:0] P_CONSEC = 8'h22;
	localparam logic [7:0] P_IDEAL = 8'h23;
	localparam logic [7:0] P_FILTER = 8'h24;
	localparam logic [7:0] P_MAKER = 8'hFE;
	localparam logic [1:0][7:0] RES_HI_PTR = {P_REMOTE_HI, P_LOCAL_HI};
	localparam logic [1:0][7:0] RES_LO_PTR = {P_REMOTE_LO, P_LOCAL_LO};
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] RST_PTR = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h08;
	localparam logic [7:0] RST_HI_LIMIT = 8'h55;
	localparam logic [7:0] RST_CRIT = 8'h6E;
	localparam logic [7:0] RST_HYST = 8'h0A;
	localparam logic [7:0] RST_CONSEC = 8'h01;
	localparam logic [7:0] CFG_MASK = 8'hE4;
	localparam logic [7:0] RATE_MASK = 8'h0F;
	localparam logic [7:0] CONSEC_MASK = 8'h8E;
	localparam logic [7:0] CONSEC_FIXED = 8'h01;
	localparam logic [7:0] FILTER_MASK = 8'h03;
	localparam logic [7:0] NIBBLE_MASK = 8'hF0;
	localparam int TIMEOUT_EN_BIT = 7;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	typedef enum logic [2:0] {
		LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_WR, LK_WR_ACK, LK_RD, LK_RD_ACK
	} stg_link_e;
endpackage

//--- src/stg_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree.
// Assumes din is asynchronous to clk; reset is asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module stg_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk, // Destination clock
	input wire logic rst, // Async reset
	input wire logic din, // Foreign level
	output logic dout // Agreed level
);
	logic s1, s2, s3;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			dout <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule // stg_sync
`default_nettype wire

//--- src/stg_timeout.sv
// Low-line watchdog: pulses trip after LIMIT consecutive cycles of run.
// Assumes run and enable are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module stg_timeout #(
	parameter int LIMIT = 16
) (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset
	input wire logic enable, // Watchdog on
	input wire logic run, // Line held low in a frame
	output logic trip // One-cycle expiry pulse
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			trip <= 1'b0;
		end else begin
			trip <= 1'b0;
			if (!enable || !run) begin
				cnt <= '0;
			end else if (cnt == CW'(LIMIT - 1)) begin
				cnt <= '0;
				trip <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule // stg_timeout
`default_nettype wire

//--- src/stg_target.sv
// Two-wire target with pointer-addressed register map of a temperature monitor.
// Assumes a free-running bus_sample_clk sampling SCL/SDA; converter side on core_clk.
// Functional notes
// R1: Each access opens with 7-bit address plus direction; only our fixed address answers.
// R2: First byte after a write-direction address loads the register pointer.
// R3: Controller sends a pointer in every write; further bytes go to selected register.
// R4: Reads return the register selected by the last written pointer.
// R5: Pointer-only write, then restart with read address, changes the read target.
// R6: Reads never change the pointer; repeated reads return the same register.
// R7: Read bytes leave most significant bit first.
// R8: Controller ends reads by not acknowledging the last wanted byte.
// R9: With timeout on, a line low 25 ms inside a frame resets the interface.
// R10: Controller keeps SCL at 1 kHz or faster during transfers.
// R11: Timeout enabled by bit 7 of the consecutive-alert register; off by default.
// R12: Controller sends the high-speed master code before running above 1 MHz.
// R13: Master code is not acknowledged and switches filters to high-speed.
// R14: High-speed filters stay until a stop condition returns them to fast mode.
// R15: Configuration, rate and four limit bytes use separate read and write pointers.
// R16: Any write to pointer 0F starts one conversion; nothing readable there.
// R17: Result bytes and status are read-only with no write pointer.
// R18: Twelve-bit values split into a high byte and bits 7:4 of a low byte.
// R19: Remote limits are twelve bits; low nibbles at 13 and 14, same pointer both ways.
// R20: Remote offset twelve bits at 11 and 12, same pointer both ways, reset zero.
// R21: Critical limits reset to 6E, hysteresis to 0A, conversion rate to 08.
// R22: Register 22 holds timeout enable and count bits 3:1, bit 0 reads 1.
// R23: Eight-bit pointer cleared at reset.
// R24: Reading one result byte freezes its partner until that partner is read; here a read of any other register also releases it.
// R25: Data writes to unmapped pointers change nothing but the pointer itself.
`timescale 1ns/1ps
`default_nettype none
module stg_target #(
	parameter int TIMEOUT_CYCLES = stg_pkg::TIMEOUT_CYCLES,
	parameter logic [7:0] MAKER_ID = stg_pkg::MAKER_ID_DEFAULT
) (
	input wire logic core_clk, // Core clock
	input wire logic sys_rst, // Async reset
	input wire logic bus_sample_clk, // Link-side clock
	input wire logic scl_in, // SCL pin level
	input wire logic sda_in, // SDA pin level
	output logic sda_out, // SDA drive value
	output logic sda_oe, // SDA pull-low enable
	output logic hs_filter_select, // High-speed filter select
	input wire logic [11:0] local_result_bits, // Local conversion result
	input wire logic [11:0] remote_result_bits, // Remote conversion result
	input wire logic result_update, // New results pulse
	input wire logic [7:0] status_flags, // Status from monitor logic
	output logic status_read, // Status read pulse
	output logic single_conversion_start, // One-shot pulse
	output logic [7:0] device_config, // Configuration byte
	output logic [3:0] rate_select_bits, // Conversion rate
	output logic [7:0] local_high_limit, // Local high limit
	output logic [7:0] local_low_limit, // Local low limit
	output logic [11:0] remote_upper_limit_bits, // Remote high limit
	output logic [11:0] remote_lower_limit_bits, // Remote low limit
	output logic [11:0] remote_offset_bits, // Remote offset
	output logic [7:0] remote_critical_bits, // Remote critical limit
	output logic [7:0] local_critical_bits, // Local critical limit
	output logic [7:0] hysteresis_bits, // Critical hysteresis
	output logic [2:0] violation_count_select, // Consecutive count
	output logic bus_timeout_enable, // Timeout on
	output logic [7:0] ideality_correction, // Ideality correction
	output logic [1:0] filter_level_bits // Averaging filter level
);
	import stg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain
	stg_link_e state;
	logic scl_s, sda_s, scl_q, sda_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [2:0] bit_cnt;
	logic got8, is_read, first_data;
	logic [7:0] rx_shift, tx_shift;
	logic wr_toggle, wr_is_ptr, rd_req_toggle, framed;
	logic [7:0] wr_byte;
	logic tmo_s, tmo_q, tmo_evt, rd_ack_s;
	logic [7:0] next_tx;

	// Core domain
	logic [7:0] pointer, cfg, rate, lhl, lll, rhl, rll, ofs_hi, ofs_lo, rhl_lo, rll_lo;
	logic [7:0] rcrit, lcrit, hyst, consec, ideal, filter, read_mux, rd_byte;
	logic [1:0][7:0] temp_hi, temp_lo;
	logic [1:0] hold_hi, hold_lo;
	logic [1:0][11:0] result;
	logic wr_s, wr_q, wr_evt, rd_s, rd_q, rd_evt, rd_ack_toggle;
	logic cscl, csda, cframed, tmo_trip, tmo_toggle;

	stg_sync #(.INIT(1'b1)) u_scl (.clk(bus_sample_clk), .rst(sys_rst), .din(scl_in), .dout(scl_s));
	stg_sync #(.INIT(1'b1)) u_sda (.clk(bus_sample_clk), .rst(sys_rst), .din(sda_in), .dout(sda_s));
	stg_sync #(.INIT(1'b0)) u_tmo (.clk(bus_sample_clk), .rst(sys_rst), .din(tmo_toggle),
		.dout(tmo_s));
	stg_sync #(.INIT(1'b0)) u_rak (.clk(bus_sample_clk), .rst(sys_rst), .din(rd_ack_toggle),
		.dout(rd_ack_s));

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
	assign tmo_evt = tmo_s ^ tmo_q;
	assign sda_out = 1'b0;
	// Byte handed over by the core; released bus if the answer is late
	assign next_tx = (rd_ack_s == rd_req_toggle) ? rd_byte : IDLE_BYTE;

	always_ff @(posedge bus_sample_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			tmo_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			tmo_q <= tmo_s;
		end
	end

	// Frame marker seen by the watchdog
	always_ff @(posedge bus_sample_clk or posedge sys_rst) begin
		if (sys_rst) begin
			framed <= 1'b0;
		end else if (tmo_evt || stop_det) begin
			framed <= 1'b0;
		end else if (start_det) begin
			framed <= 1'b1;
		end
	end

	// High-speed filter select
	always_ff @(posedge bus_sample_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hs_filter_select <= 1'b0;
		end else if (stop_det) begin
			hs_filter_select <= 1'b0; // R14
		end else if (state == LK_ADDR && scl_fall && got8 && rx_shift[7:3] == HS_CODE_TOP) begin
			hs_filter_select <= 1'b1; // R13
		end
	end

	// Serial engine
	always_ff @(posedge bus_sample_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= LK_IDLE;
			bit_cnt <= 3'h0;
			got8 <= 1'b0;
			is_read <= 1'b0;
			first_data <= 1'b0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			sda_oe <= 1'b0;
			wr_toggle <= 1'b0;
			wr_is_ptr <= 1'b0;
			wr_byte <= 8'h00;
			rd_req_toggle <= 1'b0;
		end else if (tmo_evt) begin
			state <= LK_IDLE; // R9
			sda_oe <= 1'b0; // R9
		end else if (start_det) begin
			state <= LK_ADDR; // R1
			bit_cnt <= 3'h0;
			got8 <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			state <= LK_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
				LK_ADDR, LK_WR: begin
					if (scl_rise) begin
						rx_shift <= {rx_shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 3'h1;
						got8 <= (bit_cnt == 3'h7);
					end else if (scl_fall && got8) begin
						got8 <= 1'b0;
						if (state == LK_WR) begin
							state <= LK_WR_ACK;
							sda_oe <= 1'b1;
							wr_byte <= rx_shift; // R3
							wr_is_ptr <= first_data; // R2
							first_data <= 1'b0;
							wr_toggle <= ~wr_toggle;
						end else if (rx_shift[7:1] == TARGET_ADDR) begin
							state <= LK_ADDR_ACK; // R1
							sda_oe <= 1'b1;
							is_read <= rx_shift[0];
							first_data <= ~rx_shift[0];
							if (rx_shift[0]) begin
								rd_req_toggle <= ~rd_req_toggle; // R4
							end
						end else begin
							state <= LK_IDLE; // R13
						end
					end
				end
				LK_ADDR_ACK, LK_WR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (is_read) begin
							state <= LK_RD;
							sda_oe <= ~next_tx[7]; // R7
							tx_shift <= {next_tx[6:0], 1'b0};
						end else begin
							state <= LK_WR;
							sda_oe <= 1'b0;
						end
					end
				end
				LK_RD: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							state <= LK_RD_ACK;
							sda_oe <= 1'b0;
							got8 <= 1'b0;
							rd_req_toggle <= ~rd_req_toggle; // R6
						end else begin
							sda_oe <= ~tx_shift[7]; // R7
							tx_shift <= {tx_shift[6:0], 1'b0};
							bit_cnt <= bit_cnt + 3'h1;
						end
					end
				end
				LK_RD_ACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							state <= LK_IDLE; // R8
						end else begin
							got8 <= 1'b1;
						end
					end else if (scl_fall && got8) begin
						got8 <= 1'b0;
						bit_cnt <= 3'h0;
						state <= LK_RD;
						sda_oe <= ~next_tx[7];
						tx_shift <= {next_tx[6:0], 1'b0};
					end
				end
				LK_IDLE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					state <= LK_IDLE;
				end
			endcase
		end
	end

	hs_nack_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst) // R13
		(state == LK_ADDR && scl_fall && got8 && rx_shift[7:3] == HS_CODE_TOP && !start_det
		&& !stop_det && !tmo_evt) |=> !sda_oe && hs_filter_select)
		else $error("master code acknowledged or ignored");
	hs_exit_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst) // R14
		stop_det |=> !hs_filter_select)
		else $error("high-speed filters kept after stop");
	addr_miss_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst) // R1
		(state == LK_ADDR && scl_fall && got8 && rx_shift[7:1] != TARGET_ADDR)
		|=> !sda_oe [*2])
		else $error("foreign address acknowledged");
	msb_first_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst) // R7
		(state == LK_RD && scl_fall && bit_cnt != 3'h7 && !start_det && !stop_det && !tmo_evt)
		|=> sda_oe == ~$past(tx_shift[7]))
		else $error("read bit order wrong");
	tmo_release_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst) // R9
		tmo_evt |=> !sda_oe && state == LK_IDLE && !framed)
		else $error("bus not released on timeout");

	////////////////////////////////////////////////////////////////////////////////
	// Core domain crossings
	stg_sync #(.INIT(1'b0)) u_wr (.clk(core_clk), .rst(sys_rst), .din(wr_toggle), .dout(wr_s));
	stg_sync #(.INIT(1'b0)) u_rd (.clk(core_clk), .rst(sys_rst), .din(rd_req_toggle),
		.dout(rd_s));
	stg_sync #(.INIT(1'b1)) u_cscl (.clk(core_clk), .rst(sys_rst), .din(scl_in), .dout(cscl));
	stg_sync #(.INIT(1'b1)) u_csda (.clk(core_clk), .rst(sys_rst), .din(sda_in), .dout(csda));
	stg_sync #(.INIT(1'b0)) u_frm (.clk(core_clk), .rst(sys_rst), .din(framed), .dout(cframed));

	assign wr_evt = wr_s ^ wr_q;
	assign rd_evt = rd_s ^ rd_q;
	assign result = {remote_result_bits, local_result_bits};

	stg_timeout #(.LIMIT(TIMEOUT_CYCLES)) u_wdog (
		.clk(core_clk),
		.rst(sys_rst),
		.enable(consec[TIMEOUT_EN_BIT]), // R11
		.run(cframed && (!cscl || !csda)), // R9
		.trip(tmo_trip)
	);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			tmo_toggle <= 1'b0;
		end else begin
			wr_q <= wr_s;
			rd_q <= rd_s;
			tmo_toggle <= tmo_toggle ^ tmo_trip;
		end
	end

	// Pointer: only written by the first byte of a write
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pointer <= RST_PTR; // R23
		end else if (wr_evt && wr_is_ptr) begin
			pointer <= wr_byte; // R2 R5
		end
	end

	// Writable registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg <= RST_ZERO;
			rate <= RST_RATE; // R21
			lhl <= RST_HI_LIMIT;
			lll <= RST_ZERO;
			rhl <= RST_HI_LIMIT;
			rll <= RST_ZERO;
			ofs_hi <= RST_ZERO; // R20
			ofs_lo <= RST_ZERO;
			rhl_lo <= RST_ZERO;
			rll_lo <= RST_ZERO;
			rcrit <= RST_CRIT; // R21
			lcrit <= RST_CRIT;
			hyst <= RST_HYST;
			consec <= RST_CONSEC; // R22
			ideal <= RST_ZERO;
			filter <= RST_ZERO;
		end else if (wr_evt && !wr_is_ptr) begin
			case (pointer) // R15 R17 R25
				P_CFG_WR: cfg <= wr_byte & CFG_MASK;
				P_RATE_WR: rate <= wr_byte & RATE_MASK;
				P_LHL_WR: lhl <= wr_byte;
				P_LLL_WR: lll <= wr_byte;
				P_RHL_WR: rhl <= wr_byte;
				P_RLL_WR: rll <= wr_byte;
				P_OFS_HI: ofs_hi <= wr_byte; // R20
				P_OFS_LO: ofs_lo <= wr_byte & NIBBLE_MASK;
				P_RHL_LO: rhl_lo <= wr_byte & NIBBLE_MASK; // R19
				P_RLL_LO: rll_lo <= wr_byte & NIBBLE_MASK;
				P_RCRIT: rcrit <= wr_byte;
				P_LCRIT: lcrit <= wr_byte;
				P_HYST: hyst <= wr_byte;
				P_CONSEC: consec <= (wr_byte & CONSEC_MASK) | CONSEC_FIXED; // R22
				P_IDEAL: ideal <= wr_byte;
				P_FILTER: filter <= wr_byte & FILTER_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			single_conversion_start <= 1'b0;
		end else begin
			single_conversion_start <= wr_evt && !wr_is_ptr && pointer == P_ONESHOT; // R16
		end
	end

	// Results with partner-byte freeze
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_hi <= '0;
			temp_lo <= '0;
			hold_hi <= 2'b00;
			hold_lo <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (result_update && !hold_hi[c]) begin
					temp_hi[c] <= result[c][11:4]; // R18
				end
				if (result_update && !hold_lo[c]) begin
					temp_lo[c] <= {result[c][3:0], 4'h0}; // R18
				end
				if (rd_evt) begin
					if (pointer == RES_HI_PTR[c]) begin
						hold_hi[c] <= 1'b0;
						hold_lo[c] <= !hold_hi[c]; // R24
					end else if (pointer == RES_LO_PTR[c]) begin
						hold_lo[c] <= 1'b0;
						hold_hi[c] <= !hold_lo[c]; // R24
					end else begin
						hold_hi[c] <= 1'b0;
						hold_lo[c] <= 1'b0;
					end
				end
			end
		end
	end

	always_comb begin
		read_mux = 8'h00;
		case (pointer) // R4 R15
			P_LOCAL_HI: read_mux = temp_hi[0];
			P_REMOTE_HI: read_mux = temp_hi[1];
			P_STATUS: read_mux = status_flags;
			P_CFG_RD: read_mux = cfg;
			P_RATE_RD: read_mux = rate;
			P_LHL_RD: read_mux = lhl;
			P_LLL_RD: read_mux = lll;
			P_RHL_RD: read_mux = rhl; // R19
			P_RLL_RD: read_mux = rll;
			P_REMOTE_LO: read_mux = temp_lo[1];
			P_OFS_HI: read_mux = ofs_hi;
			P_OFS_LO: read_mux = ofs_lo;
			P_RHL_LO: read_mux = rhl_lo;
			P_RLL_LO: read_mux = rll_lo;
			P_LOCAL_LO: read_mux = temp_lo[0];
			P_RCRIT: read_mux = rcrit;
			P_LCRIT: read_mux = lcrit;
			P_HYST: read_mux = hyst;
			P_CONSEC: read_mux = consec | CONSEC_FIXED; // R22
			P_IDEAL: read_mux = ideal;
			P_FILTER: read_mux = filter;
			P_MAKER: read_mux = MAKER_ID;
			default: read_mux = 8'h00;
		endcase
	end

	// Read answers; the word stays until the next request
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_byte <= 8'h00;
			rd_ack_toggle <= 1'b0;
			status_read <= 1'b0;
		end else begin
			status_read <= rd_evt && pointer == P_STATUS;
			if (rd_evt) begin
				rd_byte <= read_mux; // R4
				rd_ack_toggle <= rd_s;
			end
		end
	end

	assign device_config = cfg;
	assign rate_select_bits = rate[3:0];
	assign local_high_limit = lhl;
	assign local_low_limit = lll;
	assign remote_upper_limit_bits = {rhl, rhl_lo[7:4]};
	assign remote_lower_limit_bits = {rll, rll_lo[7:4]};
	assign remote_offset_bits = {ofs_hi, ofs_lo[7:4]};
	assign remote_critical_bits = rcrit;
	assign local_critical_bits = lcrit;
	assign hysteresis_bits = hyst;
	assign violation_count_select = consec[3:1];
	assign bus_timeout_enable = consec[TIMEOUT_EN_BIT];
	assign ideality_correction = ideal;
	assign filter_level_bits = filter[1:0];

	ptr_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		(wr_evt && wr_is_ptr) |=> pointer == $past(wr_byte) ##1 $stable(pointer) || wr_evt)
		else $error("pointer not loaded");
	oneshot_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
		(wr_evt && !wr_is_ptr && pointer == P_ONESHOT) |=> single_conversion_start
		##1 !single_conversion_start)
		else $error("one-shot pulse wrong");
	ro_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R25
		(wr_evt && !wr_is_ptr && (pointer == P_LOCAL_HI || pointer == P_REMOTE_HI))
		|=> $stable(cfg) && $stable(rate) && $stable(consec) && $stable(pointer))
		else $error("read-only write changed state");
	tmo_off_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
		!consec[TIMEOUT_EN_BIT] [*2] |-> !tmo_trip)
		else $error("timeout fired while disabled");
	rd_cfg_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		(rd_evt && pointer == P_CFG_RD) |=> rd_byte == cfg && rd_ack_toggle == $past(rd_s))
		else $error("wrong read answer");
	lock_low_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R24
		(result_update && hold_lo[0]) |=> $stable(temp_lo[0]))
		else $error("partner byte not frozen");
endmodule // stg_target
`default_nettype wire

//--- verification/stg_host.sv
// Behavioural two-wire bus controller: drives SCL, pulls SDA low.
// Assumes a pull-up resolves SDA outside; delays in ns.
`timescale 1ns/1ps
`default_nettype none
module stg_host #(
	parameter int H = 1024
) (
	output logic scl, // SCL level
	output logic sda_low, // Pull SDA low
	input wire logic sda // Resolved SDA
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		#(H/4) sda_low = 1'b0;
		#H scl = 1'b1;
		#H sda_low = 1'b1;
		#H scl = 1'b0;
	endtask
	task automatic stop();
		#(H/4) sda_low = 1'b1;
		#H scl = 1'b1;
		#H sda_low = 1'b0;
		#H;
	endtask
	// One bit slot, SDA changed only while SCL is low
	task automatic bit_x(input logic v, output logic s);
		#(H/4) sda_low = !v;
		#H scl = 1'b1;
		s = sda;
		#H scl = 1'b0;
	endtask
	task automatic wr(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(b[i], s);
		bit_x(1'b1, nak);
	endtask
	task automatic rd(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			b[i] = s;
		end
		bit_x(last, s);
	endtask
endmodule // stg_host
`default_nettype wire

//--- verification/stg_target_bench.sv
// Self-checking bench: register access of stg_target over the two-wire bus.
// Assumes stg_host as controller and a pull-up on SDA.
`timescale 1ns/1ps
`default_nettype none
module stg_target_bench;
	import stg_pkg::*;
	logic core_clk = 1'b0;
	logic bus_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic res_upd = 1'b0;
	logic conv_seen = 1'b0;
	logic sts_seen = 1'b0;
	logic scl, host_low, sda_oe, hs_sel, conv, tmo_en, sts_rd;
	logic [1:0] flt;
	logic [7:0] lhl, rcrit;
	logic [11:0] loc_res = 12'h000;
	logic [11:0] rhl;
	logic [7:0] status = 8'h00;
	logic [7:0] cfg, lcrit, hyst;
	logic [3:0] rate;
	logic [2:0] vcnt;
	int seed = 32'h0F7C;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	wire logic sda = !(sda_oe | host_low);
	always #10 core_clk = ~core_clk;
	initial #7 forever #32 bus_clk = ~bus_clk;
	stg_host u_stg_host (.scl(scl), .sda_low(host_low), .sda(sda));
	// Limit above the longest legal low stretch of a transfer (about 1100 core cycles)
	stg_target #(.TIMEOUT_CYCLES(1500)) u_stg_target (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus_sample_clk(bus_clk), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.hs_filter_select(hs_sel), .local_result_bits(loc_res), .remote_result_bits(~loc_res),
		.result_update(res_upd), .status_flags(status), .status_read(sts_rd),
		.single_conversion_start(conv), .device_config(cfg), .rate_select_bits(rate),
		.local_high_limit(lhl), .local_low_limit(), .remote_upper_limit_bits(rhl),
		.remote_lower_limit_bits(), .remote_offset_bits(), .remote_critical_bits(rcrit),
		.local_critical_bits(lcrit), .hysteresis_bits(hyst), .violation_count_select(vcnt),
		.bus_timeout_enable(tmo_en), .ideality_correction(), .filter_level_bits(flt));
	always @(posedge core_clk) begin
		if (conv)
			conv_seen <= 1'b1;
		if (sts_rd)
			sts_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fail_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lo(input logic [11:0] x);
		return {x[3:0], 4'h0};
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] p, input logic [7:0] v);
		logic n;
		u_stg_host.start();
		u_stg_host.wr({TARGET_ADDR, 1'b0}, n);
		chk(n, 12'h000);
		u_stg_host.wr(p, n);
		u_stg_host.wr(v, n);
		u_stg_host.stop();
	endtask
	task automatic reg_rd(input logic setp, input logic [7:0] p, output logic [7:0] v);
		logic n;
		u_stg_host.start();
		if (setp) begin
			u_stg_host.wr({TARGET_ADDR, 1'b0}, n);
			u_stg_host.wr(p, n);
			u_stg_host.start();
		end
		u_stg_host.wr({TARGET_ADDR, 1'b1}, n);
		u_stg_host.rd(1'b1, v);
		u_stg_host.stop();
	endtask
	task automatic upd(input logic [11:0] x);
		@(negedge core_clk) loc_res = x;
		res_upd = 1'b1;
		@(negedge core_clk) res_upd = 1'b0;
	endtask
	task automatic end_of_test();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v, r;
		logic [11:0] a;
		logic n;
		repeat (2) @(posedge bus_clk);
		@(negedge core_clk) sys_rst = 1'b0;
		status = $random(seed);
		repeat (8) @(posedge bus_clk);
		chk(rate, RST_RATE);
		chk(lcrit, RST_CRIT);
		chk(rcrit, RST_CRIT);
		chk(lhl, RST_HI_LIMIT);
		chk(hyst, RST_HYST);
		chk(rhl, {RST_HI_LIMIT, 4'h0});
		chk(tmo_en, 12'h000);
		reg_rd(1'b1, P_CONSEC, r);
		chk(r, RST_CONSEC);
		v = $random(seed);
		reg_wr(P_CFG_WR, v);
		chk(cfg, v & CFG_MASK);
		reg_rd(1'b1, P_CFG_RD, r);
		chk(r, v & CFG_MASK);
		reg_rd(1'b0, 8'h00, r);
		chk(r, v & CFG_MASK);
		reg_wr(P_REMOTE_HI, ~v);
		reg_rd(1'b0, 8'h00, r);
		chk(r, 12'h000);
		chk(cfg, v & CFG_MASK);
		reg_rd(1'b1, P_STATUS, r);
		chk(r, status);
		chk(sts_seen, 12'h001);
		reg_wr(P_ONESHOT, v);
		chk(conv_seen, 12'h001);
		a = $random(seed);
		upd(a);
		reg_rd(1'b1, P_LOCAL_HI, r);
		chk(r, a[11:4]);
		upd(~a);
		reg_rd(1'b1, P_LOCAL_LO, r);
		chk(r, lo(a));
		u_stg_host.start();
		u_stg_host.wr({TARGET_ADDR ^ 7'h01, 1'b0}, n);
		chk(n, 12'h001);
		u_stg_host.start();
		u_stg_host.wr(8'h08 | 8'($random(seed) & 7), n);
		chk(n, 12'h001);
		chk(hs_sel, 12'h001);
		u_stg_host.stop();
		chk(hs_sel, 12'h000);
		reg_wr(P_FILTER, v);
		chk(flt, v & FILTER_MASK);
		reg_wr(P_CONSEC, 8'hFF);
		chk(tmo_en, 12'h001);
		chk(vcnt, 12'h007);
		reg_rd(1'b1, P_LLL_RD, r);
		chk(r, RST_ZERO);
		u_stg_host.start();
		u_stg_host.wr({TARGET_ADDR, 1'b1}, n);
		#1000;
		chk(sda_oe, 12'h001);
		#24000;
		chk(sda_oe, 12'h001);
		#11000;
		chk(sda_oe, 12'h000);
		u_stg_host.stop();
		end_of_test();
	end
endmodule // stg_target_bench
`default_nettype wire
